/* File: verilog/ccma_core.sv */
// Call mode register, program counter flow control and data bank resolution
`timescale 1ns/1ps
module ccma_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic selWrite,
  input wire logic [3:0] selWriteData,
  output logic [3:0] stack_bank_select,
  output logic callModeBit,
  input wire logic opValid,
  input wire ccma_pkg::ccma_op_e opCode,
  input wire logic [12:0] opTarget,
  input wire logic [7:0] pairValue,
  output logic opDone,
  output logic opIllegal,
  output logic [12:0] pcValue,
  output logic [1:0] pushBytes,
  output logic [2:0] opCycles,
  output logic [3:0] stackBank,
  input wire ccma_pkg::ccma_mem_e memMode,
  input wire logic [11:0] memAddr,
  input wire logic memWide,
  input wire logic bank_enable_flag,
  input wire logic [3:0] memory_bank_select,
  output logic [3:0] active_data_bank,
  output logic memIllegal
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode register

  logic [3:0] next_stack_bank_select;

  // Software's 4-bit store replaces the whole register
  always_comb
  begin
    next_stack_bank_select = stack_bank_select;
    if (selWrite)
      next_stack_bank_select = selWriteData;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      stack_bank_select <= ccma_pkg::STACK_SEL_RESET;
    else
      stack_bank_select <= next_stack_bank_select;
  end

  // Registered value only, so a write steers the next call and not one in flight
  assign callModeBit = stack_bank_select[ccma_pkg::CALL_MODE_BIT_POS];

  ////////////////////////////////////////////////////////////////////////////
  // Program flow

  logic [12:0] next_pcValue;
  logic [1:0] next_pushBytes;
  logic [2:0] next_opCycles;
  logic next_opDone;
  logic next_opIllegal;
  logic [13:0] relSum;
  logic [4:0] relMag;
  logic relBack;

  // Relative offset: bit 12 of opTarget gives the direction, low bits the size
  assign relBack = opTarget[12];
  assign relMag = opTarget[4:0];
  assign relSum = relBack ? ({1'b0, pcValue} - {9'h000, relMag})
                          : ({1'b0, pcValue} + {9'h000, relMag});

  // Decode each flow operation into a target, a push count and, except for a table call, a cycle count
  always_comb
  begin
    next_pcValue = pcValue;
    next_pushBytes = 2'h0;
    next_opCycles = 3'h0;
    next_opDone = 1'b0;
    next_opIllegal = 1'b0;
    if (opValid)
    begin
      next_opDone = 1'b1;
      case (opCode)
        ccma_pkg::OP_ABS_BRANCH:
        begin
          next_pcValue = opTarget;
          next_opCycles = ccma_pkg::CYC_BRANCH;
        end
        ccma_pkg::OP_LONG_BRANCH, ccma_pkg::OP_LONG_CALL:
        begin
          // Short mode has no such opcodes: refuse and leave state alone
          if (callModeBit)
            next_opIllegal = 1'b1;
          else
          begin
            next_pcValue = opTarget;
            next_opCycles = ccma_pkg::CYC_BRANCH;
            if (opCode == ccma_pkg::OP_LONG_CALL)
              next_pushBytes = ccma_pkg::PUSH_LONG;
          end
        end
        ccma_pkg::OP_IN_PAGE:
        begin
          next_pcValue = {pcValue[12], opTarget[11:0]};
          next_opCycles = ccma_pkg::CYC_IN_PAGE;
        end
        ccma_pkg::OP_REL_BRANCH:
        begin
          // Offsets 0 and +1 would land inside the branch itself
          if ((relBack && (relMag == 5'h00 || relMag > ccma_pkg::REL_BACK_MAX)) ||
              (!relBack && (relMag < ccma_pkg::REL_FWD_MIN || relMag > ccma_pkg::REL_FWD_MAX)))
            next_opIllegal = 1'b1;
          else
          begin
            next_pcValue = relSum[12:0];
            next_opCycles = ccma_pkg::CYC_RELATIVE;
          end
        end
        ccma_pkg::OP_PC_DE, ccma_pkg::OP_PC_XA:
        begin
          next_pcValue = {pcValue[12:8], pairValue};
          next_opCycles = ccma_pkg::CYC_INDEXED;
        end
        ccma_pkg::OP_ABS_CALL:
        begin
          next_pcValue = opTarget;
          next_pushBytes = callModeBit ? ccma_pkg::PUSH_SHORT : ccma_pkg::PUSH_LONG;
          next_opCycles = callModeBit ? ccma_pkg::CYC_CALL_SHORT
                                      : ccma_pkg::CYC_CALL_LONG;
        end
        ccma_pkg::OP_FAST_CALL:
        begin
          next_pcValue = {2'b00, opTarget[10:0]};
          next_pushBytes = callModeBit ? ccma_pkg::PUSH_SHORT : ccma_pkg::PUSH_LONG;
          next_opCycles = callModeBit ? ccma_pkg::CYC_FAST_SHORT
                                      : ccma_pkg::CYC_FAST_LONG;
        end
        ccma_pkg::OP_TABLE_CALL:
        begin
          // Entry index must be even and inside the table window
          if (opTarget[12:7] != 6'h00 || opTarget[0] ||
              opTarget[6:0] < ccma_pkg::TABLE_LOW || opTarget[6:0] > ccma_pkg::TABLE_HIGH)
            next_opIllegal = 1'b1;
          else
          begin
            // A table call is still a subroutine call, so it stacks a return address
            next_pcValue = opTarget;
            next_pushBytes = callModeBit ? ccma_pkg::PUSH_SHORT : ccma_pkg::PUSH_LONG;
          end
        end
        default:
          next_opDone = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pcValue <= ccma_pkg::PC_RESET;
      pushBytes <= 2'h0;
      opCycles <= 3'h0;
      opDone <= 1'b0;
      opIllegal <= 1'b0;
    end
    else
    begin
      pcValue <= next_pcValue;
      pushBytes <= next_pushBytes;
      opCycles <= next_opCycles;
      opDone <= next_opDone;
      opIllegal <= next_opIllegal;
    end
  end

  // Stack lives in bank 0 whatever the mode
  assign stackBank = ccma_pkg::BANK_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Data bank resolution

  logic [3:0] next_active_data_bank;
  logic next_memIllegal;

  // Fixed-bank modes ignore the enable flag and select register entirely
  always_comb
  begin
    next_active_data_bank = ccma_pkg::BANK_ZERO;
    next_memIllegal = 1'b0;
    case (memMode)
      ccma_pkg::MA_DIRECT:
      begin
        if (bank_enable_flag)
          next_active_data_bank = memory_bank_select;
        else
          next_active_data_bank = memAddr[7] ? ccma_pkg::BANK_TOP : ccma_pkg::BANK_ZERO;
        next_memIllegal = memWide & memAddr[0];
      end
      ccma_pkg::MA_POINTER_HL:
        next_active_data_bank = bank_enable_flag ? memory_bank_select : ccma_pkg::BANK_ZERO;
      ccma_pkg::MA_POINTER_PAIR:
        next_active_data_bank = ccma_pkg::BANK_ZERO;
      ccma_pkg::MA_FMEM:
      begin
        next_active_data_bank = ccma_pkg::BANK_TOP;
        next_memIllegal = (memAddr[11:4] != 8'hfb) && (memAddr[11:4] != 8'hff);
      end
      ccma_pkg::MA_PMEM:
      begin
        next_active_data_bank = ccma_pkg::BANK_TOP;
        next_memIllegal = memAddr[11:6] != 6'h3f;
      end
      default:
        next_active_data_bank = ccma_pkg::BANK_ZERO;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      active_data_bank <= ccma_pkg::BANK_ZERO;
      memIllegal <= 1'b0;
    end
    else
    begin
      active_data_bank <= next_active_data_bank;
      memIllegal <= next_memIllegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Call requests whose push and cycle counts hang on the registered mode bit
  sequence s_call_req;
    opValid && (opCode == ccma_pkg::OP_ABS_CALL);
  endsequence

  sequence s_fast_req;
    opValid && (opCode == ccma_pkg::OP_FAST_CALL);
  endsequence

  a_reset_mode_short: assert property (@(posedge mclk)
    rst |=> callModeBit)
    else $error("mode bit not set after reset");
  a_abs_call_cycles: assert property (@(posedge mclk) disable iff (rst)
    s_call_req |=> opCycles == ($past(callModeBit) ? 3'h3 : 3'h4))
    else $error("absolute call cycle count wrong");
  a_fast_call_cycles: assert property (@(posedge mclk) disable iff (rst)
    s_fast_req |=> opCycles == ($past(callModeBit) ? 3'h2 : 3'h3))
    else $error("fast call cycle count wrong");
  a_call_push_bytes: assert property (@(posedge mclk) disable iff (rst)
    s_call_req |=> pushBytes == ($past(callModeBit) ? 2'h2 : 2'h3))
    else $error("call push byte count wrong");
  a_table_call_push: assert property (@(posedge mclk) disable iff (rst)
    (opValid && opCode == ccma_pkg::OP_TABLE_CALL && !next_opIllegal)
      |=> pushBytes == ($past(callModeBit) ? 2'h2 : 2'h3))
    else $error("table call push byte count wrong");
  a_long_op_refused: assert property (@(posedge mclk) disable iff (rst)
    (opValid && callModeBit && opCode == ccma_pkg::OP_LONG_CALL)
      |=> opIllegal && $stable(pcValue))
    else $error("long call accepted in short mode");
  a_in_page_bit: assert property (@(posedge mclk) disable iff (rst)
    (opValid && opCode == ccma_pkg::OP_IN_PAGE) |=> pcValue[12] == $past(pcValue[12]))
    else $error("in-page branch changed bit 12");
  a_fast_call_range: assert property (@(posedge mclk) disable iff (rst)
    s_fast_req |=> pcValue[12:11] == 2'b00)
    else $error("fast call left low range");
  a_indexed_upper: assert property (@(posedge mclk) disable iff (rst)
    (opValid && opCode == ccma_pkg::OP_PC_DE)
      |=> pcValue[12:8] == $past(pcValue[12:8]) && opCycles == 3'h3)
    else $error("indexed jump altered upper bits");
  a_direct_bank_low: assert property (@(posedge mclk) disable iff (rst)
    (memMode == ccma_pkg::MA_DIRECT && !bank_enable_flag && !memAddr[7])
      |=> active_data_bank == 4'h0)
    else $error("direct low operand not in bank 0");
  a_direct_bank_sel: assert property (@(posedge mclk) disable iff (rst)
    (memMode == ccma_pkg::MA_DIRECT && bank_enable_flag)
      |=> active_data_bank == $past(memory_bank_select))
    else $error("direct operand ignored bank select");
  a_wide_odd_refused: assert property (@(posedge mclk) disable iff (rst)
    (memMode == ccma_pkg::MA_DIRECT && memWide && memAddr[0]) |=> memIllegal)
    else $error("odd wide direct operand accepted");
  a_pair_bank_zero: assert property (@(posedge mclk) disable iff (rst)
    memMode == ccma_pkg::MA_POINTER_PAIR |=> active_data_bank == 4'h0)
    else $error("pointer pair not in bank 0");
  a_fmem_bank_top: assert property (@(posedge mclk) disable iff (rst)
    memMode == ccma_pkg::MA_FMEM |=> active_data_bank == 4'hf)
    else $error("special bit operand not in bank 15");
  a_mode_write_next: assert property (@(posedge mclk) disable iff (rst)
    selWrite |=> callModeBit == $past(selWriteData[3]))
    else $error("mode bit did not follow write");

endmodule // ccma_core

/* File: pkg/ccma_pkg.sv */
// Constants and types for the call mode and addressing control block
package ccma_pkg;
  localparam int CALL_MODE_BIT_POS = 3;
  localparam logic [3:0] STACK_SEL_RESET = 4'h8;
  localparam logic [1:0] PUSH_SHORT = 2'h2;
  localparam logic [1:0] PUSH_LONG = 2'h3;
  localparam logic [2:0] CYC_CALL_SHORT = 3'h3;
  localparam logic [2:0] CYC_CALL_LONG = 3'h4;
  localparam logic [2:0] CYC_FAST_SHORT = 3'h2;
  localparam logic [2:0] CYC_FAST_LONG = 3'h3;
  localparam logic [2:0] CYC_INDEXED = 3'h3;
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_IN_PAGE = 3'h2;
  localparam logic [2:0] CYC_RELATIVE = 3'h2;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [3:0] BANK_ZERO = 4'h0;
  localparam logic [3:0] BANK_TOP = 4'hf;
  localparam logic [6:0] TABLE_LOW = 7'h20;
  localparam logic [6:0] TABLE_HIGH = 7'h7f;
  localparam logic [4:0] REL_BACK_MAX = 5'h0f;
  localparam logic [4:0] REL_FWD_MIN = 5'h02;
  localparam logic [4:0] REL_FWD_MAX = 5'h10;
  typedef enum logic [3:0] {
    OP_NONE, OP_ABS_BRANCH, OP_LONG_BRANCH, OP_IN_PAGE, OP_REL_BRANCH,
    OP_PC_DE, OP_PC_XA, OP_ABS_CALL, OP_LONG_CALL, OP_FAST_CALL, OP_TABLE_CALL
  } ccma_op_e;
  typedef enum logic [2:0] {
    MA_DIRECT, MA_POINTER_HL, MA_POINTER_PAIR, MA_FMEM, MA_PMEM
  } ccma_mem_e;
endpackage

/* File: tb/tb_cpu_call_mode_and_addressing.sv */
// Self-checking bench for the call mode and addressing control block
`timescale 1ns/1ps
module tb_cpu_call_mode_and_addressing;
  logic mclk;
  logic rst;
  logic selWrite;
  logic [3:0] selWriteData;
  logic [3:0] stack_bank_select;
  logic callModeBit;
  logic opValid;
  ccma_pkg::ccma_op_e opCode;
  logic [12:0] opTarget;
  logic [7:0] pairValue;
  logic opDone;
  logic opIllegal;
  logic [12:0] pcValue;
  logic [1:0] pushBytes;
  logic [2:0] opCycles;
  logic [3:0] stackBank;
  ccma_pkg::ccma_mem_e memMode;
  logic [11:0] memAddr;
  logic memWide;
  logic bank_enable_flag;
  logic [3:0] memory_bank_select;
  logic [3:0] active_data_bank;
  logic memIllegal;
  int n_mismatch;
  int n_checks;
  int cycles;

  ccma_core uut (.mclk(mclk), .rst(rst), .selWrite(selWrite), .selWriteData(selWriteData),
    .stack_bank_select(stack_bank_select), .callModeBit(callModeBit), .opValid(opValid),
    .opCode(opCode), .opTarget(opTarget), .pairValue(pairValue), .opDone(opDone),
    .opIllegal(opIllegal), .pcValue(pcValue), .pushBytes(pushBytes), .opCycles(opCycles),
    .stackBank(stackBank), .memMode(memMode), .memAddr(memAddr), .memWide(memWide),
    .bank_enable_flag(bank_enable_flag), .memory_bank_select(memory_bank_select),
    .active_data_bank(active_data_bank), .memIllegal(memIllegal));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Watchdog: the whole run needs about 86 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles >= 1000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared compare, verdict and drivers
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One flow op, judged in the single cycle that the answer stands
  task automatic run(input string n, input ccma_pkg::ccma_op_e c, input logic [12:0] t,
    input logic [7:0] p, input logic ill, input logic [1:0] pb, input logic [2:0] cy,
    input logic [12:0] pc);
    @(posedge mclk);
    #1;
    opValid = 1'b1;
    opCode = c;
    opTarget = t;
    pairValue = p;
    @(posedge mclk);
    #1;
    opValid = 1'b0;
    chk(n, {4'h0, 1'b1, ill, pb, cy, pc}, {4'h0, opDone, opIllegal, pushBytes, opCycles, pcValue});
  endtask

  // Register write, the new value shows one cycle later
  task automatic wr(input logic [3:0] d);
    @(posedge mclk);
    #1;
    selWrite = 1'b1;
    selWriteData = d;
    @(posedge mclk);
    #1;
    selWrite = 1'b0;
    chk("modereg", {19'h0, d[3], d}, {19'h0, callModeBit, stack_bank_select});
  endtask

  // Bank lookup; on a refusal the bank value carries no meaning
  task automatic bank(input ccma_pkg::ccma_mem_e m, input logic [11:0] a, input logic w,
    input logic f, input logic [3:0] s, input logic ill, input logic [3:0] b);
    @(posedge mclk);
    #1;
    memMode = m;
    memAddr = a;
    memWide = w;
    bank_enable_flag = f;
    memory_bank_select = s;
    @(posedge mclk);
    #1;
    if (ill)
      chk("memill", 24'h1, {23'h0, memIllegal});
    else
      chk("bank", {19'h0, 1'b0, b}, {19'h0, memIllegal, active_data_bank});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("rstmode", {19'h0, 1'b1, 4'h8}, {19'h0, callModeBit, stack_bank_select});
    chk("rstpc", 24'h0, {7'h0, stackBank, pcValue});
    chk("rstop", 24'h0, {17'h0, opDone, opIllegal, pushBytes, opCycles});
    chk("rstbank", 24'h0, {19'h0, memIllegal, active_data_bank});
  endtask

  // Reset in mid-run from long mode must bring back short mode at once
  task automatic t_rerst();
    wr(4'h0);
    @(posedge mclk);
    #1;
    rst = 1'b1;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("rrmode", {19'h0, 1'b1, 4'h8}, {19'h0, callModeBit, stack_bank_select});
    chk("rrpc", 24'h0, {11'h0, pcValue});
    run("rrlcall", ccma_pkg::OP_LONG_CALL, 13'h0200, 8'h0, 1, 0, 0, 13'h0000);
  endtask

  task automatic t_short();
    run("call", ccma_pkg::OP_ABS_CALL, 13'h1234, 8'h0, 0, 2, 3, 13'h1234);
    run("fast", ccma_pkg::OP_FAST_CALL, 13'h07ff, 8'h0, 0, 2, 2, 13'h07ff);
    run("lbr", ccma_pkg::OP_LONG_BRANCH, 13'h1fff, 8'h0, 1, 0, 0, 13'h07ff);
    run("lcall", ccma_pkg::OP_LONG_CALL, 13'h0100, 8'h0, 1, 0, 0, 13'h07ff);
  endtask

  task automatic t_long();
    wr(4'h0);
    run("call", ccma_pkg::OP_ABS_CALL, 13'h1fff, 8'h0, 0, 3, 4, 13'h1fff);
    run("fast", ccma_pkg::OP_FAST_CALL, 13'h0100, 8'h0, 0, 3, 3, 13'h0100);
    run("lbr", ccma_pkg::OP_LONG_BRANCH, 13'h0abc, 8'h0, 0, 0, 3, 13'h0abc);
    run("lcall", ccma_pkg::OP_LONG_CALL, 13'h1555, 8'h0, 0, 3, 3, 13'h1555);
  endtask

  // A write in the cycle of a call only governs later calls
  task automatic t_same_cycle();
    @(posedge mclk);
    #1;
    selWrite = 1'b1;
    selWriteData = 4'h8;
    opValid = 1'b1;
    opCode = ccma_pkg::OP_ABS_CALL;
    opTarget = 13'h0040;
    @(posedge mclk);
    #1;
    selWrite = 1'b0;
    opValid = 1'b0;
    chk("samecnt", {19'h0, 2'h3, 3'h4}, {19'h0, pushBytes, opCycles});
    chk("samepc", {9'h0, 1'b1, 1'b0, 13'h0040}, {9'h0, opDone, opIllegal, pcValue});
    run("next", ccma_pkg::OP_FAST_CALL, 13'h0020, 8'h0, 0, 2, 2, 13'h0020);
  endtask

  task automatic t_flow();
    run("abr", ccma_pkg::OP_ABS_BRANCH, 13'h1234, 8'h0, 0, 0, 3, 13'h1234);
    run("page", ccma_pkg::OP_IN_PAGE, 13'h0abc, 8'h0, 0, 0, 2, 13'h1abc);
    run("fwd16", ccma_pkg::OP_REL_BRANCH, 13'h0010, 8'h0, 0, 0, 2, 13'h1acc);
    run("back15", ccma_pkg::OP_REL_BRANCH, 13'h100f, 8'h0, 0, 0, 2, 13'h1abd);
    run("fwd1", ccma_pkg::OP_REL_BRANCH, 13'h0001, 8'h0, 1, 0, 0, 13'h1abd);
    run("back16", ccma_pkg::OP_REL_BRANCH, 13'h1010, 8'h0, 1, 0, 0, 13'h1abd);
    run("pc_plus_de_jump", ccma_pkg::OP_PC_DE, 13'h0000, 8'h5a, 0, 0, 3, 13'h1a5a);
    run("pc_plus_xa_jump", ccma_pkg::OP_PC_XA, 13'h0000, 8'h00, 0, 0, 3, 13'h1a00);
    run("todd", ccma_pkg::OP_TABLE_CALL, 13'h0021, 8'h0, 1, 0, 0, 13'h1a00);
    run("tlow", ccma_pkg::OP_TABLE_CALL, 13'h001e, 8'h0, 1, 0, 0, 13'h1a00);
    run("thigh", ccma_pkg::OP_TABLE_CALL, 13'h0080, 8'h0, 1, 0, 0, 13'h1a00);
    run("tok", ccma_pkg::OP_TABLE_CALL, 13'h007e, 8'h0, 0, 2, 0, 13'h007e);
  endtask

  task automatic t_bank();
    bank(ccma_pkg::MA_DIRECT, 12'h010, 0, 0, 4'hf, 0, 4'h0);
    bank(ccma_pkg::MA_DIRECT, 12'hf90, 0, 0, 4'h0, 0, 4'hf);
    bank(ccma_pkg::MA_DIRECT, 12'h034, 0, 1, 4'hf, 0, 4'hf);
    bank(ccma_pkg::MA_POINTER_PAIR, 12'h010, 0, 1, 4'hf, 0, 4'h0);
    bank(ccma_pkg::MA_POINTER_HL, 12'h010, 0, 1, 4'hf, 0, 4'hf);
    bank(ccma_pkg::MA_POINTER_HL, 12'h010, 0, 0, 4'hf, 0, 4'h0);
    bank(ccma_pkg::MA_FMEM, 12'hfb3, 0, 0, 4'h0, 0, 4'hf);
    bank(ccma_pkg::MA_FMEM, 12'hff0, 0, 1, 4'h0, 0, 4'hf);
    bank(ccma_pkg::MA_PMEM, 12'hfc0, 0, 1, 4'h0, 0, 4'hf);
    bank(ccma_pkg::MA_FMEM, 12'hfc0, 0, 0, 4'h0, 1, 4'h0);
    bank(ccma_pkg::MA_DIRECT, 12'h021, 1, 0, 4'h0, 1, 4'h0);
    bank(ccma_pkg::MA_DIRECT, 12'h020, 1, 0, 4'h0, 0, 4'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: eight cycles of reset, then every scenario in turn
  initial
  begin
    {n_mismatch, n_checks, cycles} = '0;
    {rst, selWrite, selWriteData, opValid, opTarget, pairValue} = {1'b1, 27'h0};
    {memAddr, memWide, bank_enable_flag, memory_bank_select} = 18'h0;
    opCode = ccma_pkg::OP_NONE;
    memMode = ccma_pkg::MA_DIRECT;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_short();
    t_long();
    t_same_cycle();
    t_flow();
    t_bank();
    t_rerst();
    wr(4'h8);
    summarize();
  end
endmodule // tb_cpu_call_mode_and_addressing
